//--- core/eac_gate.sv
`timescale 1ns/10ps
// Summary of operation
// - address-only command means open channel
// - long address-only open replies with echo, checksum
// - unaddressed units close on short prompt
// - open plus module command: no reply, forward
// - short explicit close replies single star
// - long explicit close echoes and checksums
// - explicit open confirms like close
// - trailing checksum accepted on open, close
// - normal extended mode parses prompt, address, command
// - transparent mode forwards every character
// - ten-bit frame, seven plus parity or eight
// - transparent mode gives RTS/CTS handshake
// - transparent set only by setup write
// - setup bit4 filter off, bit5 transparent
// - default pin: any address, 300 baud
// - gate closed after power-up
// - any extended prompt closes gate silently
// - address characters from the legal set
// - open gate passes data, closed blocks
module eac_gate
  import eac_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic HOST_VALID,
  input wire logic [7:0] HOST_DATA,
  output logic BUS_VALID,
  output logic [7:0] BUS_DATA,
  output logic REPLY_VALID,
  output logic [7:0] REPLY_DATA,
  input wire logic REPLY_READY,
  input wire logic DEFAULT_N,
  input wire logic RTS,
  output logic CTS,
  output logic DEFAULT_MODE,
  output logic FRAME_EIGHT
);
  eac_rpl_if rpl ();
  eac_pstate_t state;
  logic [7:0] setup;
  logic [15:0] own_addr;
  logic wr_armed;
  logic gate_open;
  logic long_form;
  logic match;
  logic [7:0] addr_hi;
  logic [15:0] cmd;
  logic [1:0] tail;
  logic [1:0] pins_s;
  logic default_s;
  logic rts_s;
  logic apb_acc;
  logic apb_wr;
  logic parse_on;
  logic transp;
  logic ext_prompt;
  logic at_cr;
  logic implied_open;
  logic module_open;
  logic explicit_end;
  logic open_ev;
  logic close_ev;
  logic reply_ev;
  logic pass;
  logic [31:0] next_rdata;

  eac_sync #(.W(2)) u_sync (
    .clk(MCLK),
    .rst(RESET),
    .din({~DEFAULT_N, RTS}),
    .dout(pins_s)
  );
  assign default_s = pins_s[1];
  assign rts_s = pins_s[0];

  eac_reply u_reply (
    .clk(MCLK),
    .rst(RESET),
    .rq(rpl.ctl),
    .tx_valid(REPLY_VALID),
    .tx_data(REPLY_DATA),
    .tx_ready(REPLY_READY)
  );

  assign transp = setup[SU_TRANSP_BIT];
  // parse only in normal extended mode
  assign parse_on = HOST_VALID && !transp && setup[SU_EXT_BIT];
  assign ext_prompt = parse_on && eac_is_ext_prompt(HOST_DATA);
  assign at_cr = HOST_DATA == CH_CR;
  assign implied_open = parse_on && !ext_prompt && state == PS_CMD1 && at_cr;
  assign module_open = parse_on && !ext_prompt && state == PS_CMD1 && (HOST_DATA == CH_DOLLAR || HOST_DATA == CH_HASH);
  // checksum characters may sit before CR
  assign explicit_end = parse_on && !ext_prompt && state == PS_TAIL && at_cr;
  assign open_ev = match && (implied_open || module_open || (explicit_end && cmd == CMD_OPEN));
  assign close_ev = match && explicit_end && cmd == CMD_CLOSE;
  assign reply_ev = match && (implied_open || (explicit_end && (cmd == CMD_OPEN || cmd == CMD_CLOSE)));

  // apb: one wait state, unmapped reads zero with slave error
  assign apb_acc = PSEL && PENABLE && PREADY;
  assign apb_wr = apb_acc && PWRITE;

  always_comb begin
    next_rdata = '0;
    case (PADDR)
      REG_SETUP: next_rdata = {24'h000000, setup};
      REG_ADDR: next_rdata = {16'h0000, own_addr};
      REG_STATUS: next_rdata = {27'h0000000, wr_armed, rts_s, default_s, transp, gate_open};
      REG_WREN: next_rdata = {31'h00000000, wr_armed};
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      PREADY <= 1'b0;
      PRDATA <= '0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && PENABLE && !PREADY;
      PRDATA <= next_rdata;
      PSLVERR <= PSEL && PENABLE && !PREADY && !(PADDR == REG_SETUP || PADDR == REG_ADDR ||
                 PADDR == REG_STATUS || PADDR == REG_WREN);
    end
  end

  // setup write needs a fresh write enable
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      wr_armed <= 1'b0;
    end else if (apb_wr && PADDR == REG_WREN) begin
      wr_armed <= PWDATA[0];
    end else if (apb_wr && (PADDR == REG_SETUP || PADDR == REG_ADDR)) begin
      wr_armed <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      setup <= SETUP_RESET;
      own_addr <= ADDR_RESET;
    end else if (apb_wr && wr_armed) begin
      if (PADDR == REG_SETUP) begin
        setup <= PWDATA[7:0];
        if (transp && !default_s) begin
          setup[SU_TRANSP_BIT] <= 1'b1;
        end
      end
      if (PADDR == REG_ADDR && eac_addr_legal(PWDATA[15:8]) && eac_addr_legal(PWDATA[7:0])) begin
        own_addr <= PWDATA[15:0];
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      state <= PS_IDLE;
      long_form <= 1'b0;
      match <= 1'b0;
      addr_hi <= CH_NUL;
      cmd <= '0;
      tail <= '0;
    end else if (ext_prompt) begin
      state <= PS_ADDR1;
      long_form <= HOST_DATA == CH_LONG;
      match <= 1'b0;
    end else if (parse_on) begin
      case (state)
        PS_ADDR1: begin
          addr_hi <= HOST_DATA;
          state <= eac_addr_legal(HOST_DATA) ? PS_ADDR2 : PS_SKIP;
        end
        PS_ADDR2: begin
          match <= default_s || {addr_hi, HOST_DATA} == own_addr;
          state <= eac_addr_legal(HOST_DATA) ? PS_CMD1 : PS_SKIP;
        end
        PS_CMD1: begin
          cmd[15:8] <= HOST_DATA;
          state <= at_cr ? PS_IDLE : (module_open ? PS_FWD : PS_CMD2);
        end
        PS_CMD2: begin
          cmd[7:0] <= HOST_DATA;
          tail <= '0;
          state <= at_cr ? PS_IDLE : PS_TAIL;
        end
        PS_TAIL: begin
          tail <= tail + 2'h1;
          state <= at_cr ? PS_IDLE : (tail == TAIL_MAX ? PS_SKIP : PS_TAIL);
        end
        PS_FWD, PS_SKIP: state <= at_cr ? PS_IDLE : state;
        default: state <= PS_IDLE;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      gate_open <= 1'b0;
    end else if (ext_prompt) begin
      // any prompt closes, addressed or not
      gate_open <= 1'b0;
    end else if (open_ev) begin
      gate_open <= 1'b1;
    end else if (close_ev) begin
      gate_open <= 1'b0;
    end
  end

  // reply request, long or short form
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      rpl.start <= 1'b0;
      rpl.long_form <= 1'b0;
      rpl.addr <= '0;
      rpl.cmd <= '0;
    end else begin
      rpl.start <= reply_ev;
      rpl.long_form <= long_form;
      rpl.addr <= own_addr;
      rpl.cmd <= implied_open ? CMD_OPEN : cmd;
    end
  end

  always_comb begin
    pass = 1'b0;
    if (transp) begin
      pass = 1'b1;
    end else if (!setup[SU_EXT_BIT]) begin
      pass = 1'b1;
    end else if (!ext_prompt) begin
      pass = (match && module_open) || (gate_open && (state == PS_IDLE || state == PS_FWD));
    end
    // filter drops nulls outside transparent mode unless switched off
    if (!transp && !setup[SU_FILTER_OFF_BIT] && HOST_DATA == CH_NUL) begin
      pass = 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      BUS_VALID <= 1'b0;
      BUS_DATA <= CH_NUL;
    end else begin
      BUS_VALID <= HOST_VALID && pass;
      BUS_DATA <= HOST_DATA;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      CTS <= 1'b0;
      DEFAULT_MODE <= 1'b0;
      FRAME_EIGHT <= 1'b0;
    end else begin
      CTS <= transp && rts_s;
      DEFAULT_MODE <= default_s;
      // frame width select for the uart
      FRAME_EIGHT <= setup[SU_EIGHT_BIT];
    end
  end

  sequence s_prompt;
    ext_prompt;
  endsequence
  sequence s_gate_shut;
    !gate_open;
  endsequence

  AST_RESET_CLOSED: assert property (@(posedge MCLK) RESET |=> !gate_open)
    else $error("gate open after reset");
  AST_PROMPT_CLOSES: assert property (@(posedge MCLK) disable iff (RESET) s_prompt |=> s_gate_shut)
    else $error("prompt did not close the gate");
  AST_IMPLIED_OPEN: assert property (@(posedge MCLK) disable iff (RESET)
    (implied_open && match) |=> gate_open ##1 REPLY_VALID)
    else $error("address-only command did not open and reply");
  AST_CLOSE_REPLY: assert property (@(posedge MCLK) disable iff (RESET)
    (close_ev && !rpl.busy) |=> (!gate_open && rpl.start) ##1 (REPLY_VALID && REPLY_DATA == CH_STAR))
    else $error("explicit close not confirmed");
  AST_MODULE_SILENT: assert property (@(posedge MCLK) disable iff (RESET)
    (match && module_open) |=> (!rpl.start && BUS_VALID && gate_open))
    else $error("module command after open mishandled");
  AST_TRANSP_PASS: assert property (@(posedge MCLK) disable iff (RESET)
    (HOST_VALID && transp) |=> (BUS_VALID && BUS_DATA == $past(HOST_DATA)))
    else $error("transparent character not forwarded");
  AST_CLOSED_BLOCKS: assert property (@(posedge MCLK) disable iff (RESET)
    (parse_on && !gate_open && state == PS_IDLE && !module_open) |=> !BUS_VALID)
    else $error("character passed a closed gate");
  AST_CTS_QUIET: assert property (@(posedge MCLK) disable iff (RESET) (!transp) [*2] |-> !CTS)
    else $error("handshake outside transparent mode");
  AST_SETUP_NEEDS_WREN: assert property (@(posedge MCLK) disable iff (RESET)
    (apb_wr && PADDR == REG_SETUP && !wr_armed) |=> $stable(setup))
    else $error("setup changed without write enable");
endmodule // eac_gate

//--- core/eac_pkg.sv
package eac_pkg;
  // characters of the command stream
  localparam logic [7:0] CH_SHORT = 8'h7B;
  localparam logic [7:0] CH_LONG = 8'h7D;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_NUL = 8'h00;
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_O = 8'h4F;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_A_MINUS_10 = 8'h37;
  localparam logic [15:0] CMD_OPEN = {CH_O, CH_C};
  localparam logic [15:0] CMD_CLOSE = {CH_C, CH_C};

  // apb map
  localparam logic [7:0] REG_SETUP = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_WREN = 8'h0C;

  // setup byte fields
  localparam int SU_EXT_BIT = 0;
  localparam int SU_FILTER_OFF_BIT = 4;
  localparam int SU_TRANSP_BIT = 5;
  localparam int SU_EIGHT_BIT = 6;
  localparam logic [7:0] SETUP_RESET = 8'h01;
  localparam logic [15:0] ADDR_RESET = 16'h3031;
  localparam logic [1:0] TAIL_MAX = 2'h2;

  typedef enum {PS_IDLE, PS_ADDR1, PS_ADDR2, PS_CMD1, PS_CMD2, PS_TAIL, PS_FWD, PS_SKIP} eac_pstate_t;

  function automatic logic eac_is_ext_prompt(input logic [7:0] c);
    return (c == CH_SHORT) || (c == CH_LONG);
  endfunction

  function automatic logic eac_addr_legal(input logic [7:0] c);
    return !((c == CH_NUL) || (c == CH_CR) || (c == CH_DOLLAR) || (c == CH_HASH) || eac_is_ext_prompt(c));
  endfunction

  function automatic logic [7:0] eac_hex(input logic [3:0] n);
    return (n < 4'hA) ? CH_ZERO + {4'h0, n} : CH_A_MINUS_10 + {4'h0, n};
  endfunction
endpackage

//--- core/eac_rpl_if.sv
`timescale 1ns/10ps
interface eac_rpl_if;
  logic start;
  logic long_form;
  logic [15:0] addr;
  logic [15:0] cmd;
  logic busy;
  modport ctl (output start, output long_form, output addr, output cmd, input busy);
  modport gen (input start, input long_form, input addr, input cmd, output busy);
endinterface

//--- core/eac_sync.sv
`timescale 1ns/10ps
module eac_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;
  // meta is read by dout only
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // eac_sync

//--- core/eac_reply.sv
`timescale 1ns/10ps
module eac_reply
  import eac_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  eac_rpl_if.gen rq,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready
);
  logic [2:0] idx;
  logic long_form;
  logic [15:0] addr;
  logic [15:0] cmd;
  logic [7:0] csum;
  logic [7:0] next_data;

  assign rq.busy = tx_valid;

  // long form echoes, checksums
  // checksum over star, address and command letters
  always_comb begin
    csum = CH_STAR + addr[15:8] + addr[7:0] + cmd[15:8] + cmd[7:0];
    case (idx)
      3'h1: next_data = long_form ? addr[15:8] : CH_CR;
      3'h2: next_data = addr[7:0];
      3'h3: next_data = cmd[15:8];
      3'h4: next_data = cmd[7:0];
      3'h5: next_data = eac_hex(csum[7:4]);
      3'h6: next_data = eac_hex(csum[3:0]);
      default: next_data = CH_CR;
    endcase
  end

  // a start while busy is dropped; the parser can issue one that fast during a long reply
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_valid <= 1'b0;
      tx_data <= CH_NUL;
      idx <= 3'h0;
      long_form <= 1'b0;
      addr <= '0;
      cmd <= '0;
    end else if (!tx_valid && rq.start) begin
      tx_valid <= 1'b1;
      tx_data <= CH_STAR;
      idx <= 3'h1;
      long_form <= rq.long_form;
      addr <= rq.addr;
      cmd <= rq.cmd;
    end else if (tx_valid && tx_ready) begin
      if (tx_data == CH_CR) begin
        tx_valid <= 1'b0;
      end else begin
        tx_data <= next_data;
        idx <= idx + 3'h1;
      end
    end
  end

  AST_SHORT_STAR: assert property (@(posedge clk) disable iff (rst)
    (rq.start && !rq.long_form && !tx_valid) |=> (tx_valid && tx_data == CH_STAR))
    else $error("short reply does not open with a star");
  AST_LONG_ECHO: assert property (@(posedge clk) disable iff (rst)
    (rq.start && rq.long_form && !tx_valid) ##1 (tx_valid && tx_ready) |=> (tx_data == addr[15:8]))
    else $error("long reply does not echo the address");
endmodule // eac_reply

//--- tb/eac_host_model.sv
`timescale 1ns/10ps
module eac_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic valid,
  input wire logic [7:0] data,
  output logic ready
);
  logic [1:0] pace;
  logic [7:0] got[$];
  // host only listens while a reply runs
  always_ff @(posedge clk) begin
    if (rst) begin
      pace <= 2'h0;
    end else begin
      pace <= pace + 2'h1;
      if (valid && ready) begin
        got.push_back(data);
      end
    end
  end
  // stall one cycle in four, so holding is exercised
  assign ready = ~rst & (pace != 2'h1);
endmodule // eac_host_model

//--- tb/eac_gate_test.sv
`timescale 1ns/10ps
module eac_gate_test
  import eac_pkg::*;
;
  logic mclk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, host_data, bus_data, reply_data;
  logic [31:0] pwdata, prdata, rd;
  logic host_valid, bus_valid, reply_valid, reply_ready, default_n, rts, cts, default_mode, frame_eight, err;
  logic [7:0] bus_q[$];
  int mismatches = 0;
  int check_count = 0;
  string cmd[7] = '{"{01", "{02", "}01", "{01CC", "{01OC", "}01CC", "}01OC12"};
  string rsp[7] = '{"*\015", "", "*01OC1D\015", "*\015", "*\015", "*01CC11\015", "*01OC1D\015"};
  logic gate[7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  eac_gate u_eac_gate (.MCLK(mclk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .HOST_VALID(host_valid), .HOST_DATA(host_data), .BUS_VALID(bus_valid), .BUS_DATA(bus_data),
    .REPLY_VALID(reply_valid), .REPLY_DATA(reply_data), .REPLY_READY(reply_ready),
    .DEFAULT_N(default_n), .RTS(rts), .CTS(cts), .DEFAULT_MODE(default_mode), .FRAME_EIGHT(frame_eight));
  eac_host_model u_host (.clk(mclk), .rst(reset), .valid(reply_valid), .data(reply_data), .ready(reply_ready));

  always @(posedge mclk) begin
    if (bus_valid === 1'b1) begin
      bus_q.push_back(bus_data);
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_txt(input logic [7:0] q[$], input string s);
    chk(32'(q.size()), 32'(s.len()));
    for (int i = 0; i < s.len() && i < q.size(); i++) begin
      chk({24'h0, q[i]}, {24'h0, s[i]});
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // no wait limit here; the watchdog ends a hang
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, exp_err});
  endtask

  task automatic send(input string s, input bit cr);
    for (int i = 0; i < s.len(); i++) begin
      host_valid <= 1'b1;
      host_data <= s[i];
      @(posedge mclk);
    end
    if (cr) begin
      host_valid <= 1'b1;
      host_data <= CH_CR;
      @(posedge mclk);
    end
    host_valid <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic reply_is(input string s);
    int n;
    n = 0;
    while (u_host.got.size() < s.len() && n < 300) begin
      @(posedge mclk);
      n++;
    end
    repeat (20) @(posedge mclk);
    chk_txt(u_host.got, s);
    u_host.got.delete();
  endtask

  task automatic gate_is(input logic open);
    bus_q.delete();
    send("A", 1'b0);
    repeat (2) @(posedge mclk);
    chk(32'(bus_q.size()), {31'h0, open});
  endtask

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // whole run is several hundred cycles; cut off far beyond
  initial begin
    #2000000;
    mismatches++;
    end_sim();
  end

  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    host_valid = 1'b0;
    host_data = 8'h00;
    default_n = 1'b1;
    rts = 1'b0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    gate_is(1'b0);
    rd_chk(REG_ADDR, 32'h3031, 1'b0);
    rd_chk(REG_SETUP, 32'h1, 1'b0);
    apb(1'b1, REG_SETUP, 32'h0);
    rd_chk(REG_SETUP, 32'h1, 1'b0);
    apb(1'b1, REG_WREN, 32'h1);
    apb(1'b1, REG_ADDR, 32'h7B30);
    rd_chk(REG_ADDR, 32'h3031, 1'b0);
    rd_chk(8'h10, 32'h0, 1'b1);
    for (int i = 0; i < 7; i++) begin
      send(cmd[i], 1'b1);
      reply_is(rsp[i]);
      gate_is(gate[i]);
    end
    rd_chk(REG_STATUS, 32'h1, 1'b0);
    bus_q.delete();
    send("{01$1RD", 1'b1);
    reply_is("");
    chk_txt(bus_q, "$1RD\015");
    apb(1'b1, REG_WREN, 32'h1);
    apb(1'b1, REG_SETUP, 32'h71);
    rd_chk(REG_SETUP, 32'h71, 1'b0);
    chk({31'h0, frame_eight}, 32'h1);
    rts <= 1'b1;
    repeat (5) @(posedge mclk);
    chk({31'h0, cts}, 32'h1);
    bus_q.delete();
    send("{99", 1'b1);
    reply_is("");
    chk_txt(bus_q, "{99\015");
    apb(1'b1, REG_WREN, 32'h1);
    apb(1'b1, REG_SETUP, 32'h01);
    rd_chk(REG_SETUP, 32'h21, 1'b0);
    default_n <= 1'b0;
    repeat (5) @(posedge mclk);
    chk({31'h0, default_mode}, 32'h1);
    apb(1'b1, REG_WREN, 32'h1);
    apb(1'b1, REG_SETUP, 32'h01);
    rd_chk(REG_SETUP, 32'h01, 1'b0);
    repeat (3) @(posedge mclk);
    chk({31'h0, cts}, 32'h0);
    send("{77", 1'b1);
    reply_is("*\015");
    default_n <= 1'b1;
    repeat (5) @(posedge mclk);
    chk({31'h0, default_mode}, 32'h0);
    end_sim();
  end
endmodule // eac_gate_test
